// File: hs_pwm_pkg.sv
// Summary of operation
// - bus event with mask bit 2 set gives one low pulse on irq_out_n.
// - temperature event with mask bit 1 set gives one interrupt pulse.
// - supply event with mask bit 0 set gives one interrupt pulse.
// - mask resets to 0x0140; restart clears 15:9 and keeps 8:0.
// - setup bit 14 picks generator period: 0 is 100 Hz, 1 is 200 Hz.
// - duty in bits 13:4 sets on-time in 1/1024 steps; zero off, ones on.
// - bank bits 2:0 pick generator one to four; codes 1xx are ignored.
// - setup bits 15 and 3 always read as zero.
// - setup clears on reset; restart keeps 14:4, clears 15 and 3:0.
// - generators only drive the integrated high-side switches, not bridge inputs.
// - generator output is trusted only after one full period since setup.
// - scratch register holds 16 host bits the block never alters.
// - scratch clears on reset and survives restart and fail-safe.
// - scratch register is reachable only in normal mode.
// - every enabled event gives a fresh pulse, even if flag already set.
// - switch code 0100 follows generator one, next codes generators two to four.
//
// Purpose: constants and types for the high-side generator and mask registers
// Assumes: 10 MHz mclk
// Notes:   register index equals address on the internal register port
package hs_pwm_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 16;
  localparam logic [6:0]  ADDR_MASK     = 7'h09;
  localparam logic [6:0]  ADDR_SETUP    = 7'h0A;
  localparam logic [6:0]  ADDR_SCRATCH  = 7'h0B;

  localparam logic [15:0] MASK_RESET    = 16'h0140;
  localparam int          MASK_KEEP_W   = 9;
  localparam int          BIT_SUPPLY    = 0;
  localparam int          BIT_TEMP      = 1;
  localparam int          BIT_BUS       = 2;

  localparam int          BIT_PERIOD    = 14;
  localparam int          DUTY_LSB      = 4;
  localparam int          DUTY_W        = 10;
  localparam int          BANK_LSB      = 0;
  localparam int          BANK_W        = 3;
  localparam int          NUM_GEN       = 4;
  localparam logic [9:0]  DUTY_FULL     = 10'h3FF;

  localparam int          NUM_HS        = 3;
  localparam logic [3:0]  HS_CODE_GEN1  = 4'h4;

  // period times in ns, step = one of 1024 duty slots, rounded down
  localparam int          CLK_NS        = 100;
  localparam int          PERIOD_SLOW_NS = 10_000_000;
  localparam int          PERIOD_FAST_NS = 5_000_000;
  localparam int          STEP_SLOW     = PERIOD_SLOW_NS / (CLK_NS * 1024);
  localparam int          STEP_FAST     = PERIOD_FAST_NS / (CLK_NS * 1024);
  localparam int          STEP_W        = 8;

  typedef struct packed {
    logic       period_fast;
    logic [9:0] duty;
  } gen_cfg_t;

  typedef struct packed {
    logic bus_ev;
    logic temp_ev;
    logic supply_ev;
  } event_t;
endpackage : hs_pwm_pkg

// File: hs_pwm_gen.sv
// Purpose: one internal high-side generator, 10-bit counter with step divider
// Assumes: cfg stable between load pulses
// Notes:   settled flags one full period after the last load
`timescale 1ns/100ps
module hs_pwm_gen
  import hs_pwm_pkg::*;
(
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     nrst,
  // setup
  input  wire gen_cfg_t cfg,
  input  wire logic     load,
  // output
  output logic          pwm_out,
  output logic          settled
);
  logic [STEP_W-1:0] div;
  logic [9:0]        cnt;
  logic              tick;
  logic [STEP_W-1:0] step_max;

  assign step_max = cfg.period_fast ? STEP_W'(STEP_FAST - 1) : STEP_W'(STEP_SLOW - 1);
  assign tick     = (div == step_max);

  always_ff @(posedge mclk) begin
    if (!nrst || load || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || load) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (cfg.duty == DUTY_FULL) || (cnt < cfg.duty);
    end
  end

  // first period after setup is untrusted
  always_ff @(posedge mclk) begin
    if (!nrst || load) begin
      settled <= 1'b0;
    end else if (tick && cnt == DUTY_FULL) begin
      settled <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_duty_zero_off: assert property (cfg.duty == '0 && $stable(cfg.duty) |=> !pwm_out)
    else $error("zero duty drove output high");
  a_duty_full_on: assert property (cfg.duty == DUTY_FULL && $stable(cfg.duty) |=> pwm_out)
    else $error("full duty drove output low");
endmodule : hs_pwm_gen

// File: hs_pwm_irq_mask_regs.sv
// Purpose: interrupt mask, generator setup and host scratch registers
// Assumes: register port and events come from logic on mclk
// Notes:   restart is a one-cycle request from the mode controller
`timescale 1ns/100ps
module hs_pwm_irq_mask_regs
  import hs_pwm_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // device mode
  input  wire logic                  restart,
  input  wire logic                  normal_mode,
  // register port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  output logic      [DATA_W-1:0]     reg_rdata,
  // status events
  input  wire event_t                events,
  output logic                       irq_out_n,
  // high-side switches
  input  wire logic [4*NUM_HS-1:0]   highside_switch_cfg,
  output logic      [NUM_HS-1:0]     highside_switch_pwm,
  output logic      [NUM_HS-1:0]     highside_switch_by_gen,
  output logic      [NUM_GEN-1:0]    generator_out,
  output logic      [NUM_GEN-1:0]    generator_settled
);
  logic [MASK_KEEP_W-1:0] mask_bits;
  logic                   generator_period_select;
  logic [DUTY_W-1:0]      generator_duty_value;
  logic [BANK_W-1:0]      generator_bank_select;
  logic [DATA_W-1:0]      host_config_bits;
  gen_cfg_t               gen_cfg [NUM_GEN];
  logic [NUM_GEN-1:0]     gen_load;
  logic [DATA_W-1:0]      next_rdata;
  logic                   wr_mask;
  logic                   wr_setup;
  logic                   wr_scratch;
  logic                   irq_hit;

  // bank codes 1xx name no generator
  function automatic logic bank_valid(input logic [DATA_W-1:0] w);
    return !w[BANK_LSB + BANK_W - 1];
  endfunction : bank_valid

  // generator copy of a setup word
  function automatic gen_cfg_t pack_cfg(input logic [DATA_W-1:0] w);
    return '{period_fast: w[BIT_PERIOD],
             duty:        w[DUTY_LSB +: DUTY_W]};
  endfunction : pack_cfg

  assign wr_mask    = reg_wr && reg_addr == ADDR_MASK;
  assign wr_setup   = reg_wr && reg_addr == ADDR_SETUP;
  assign wr_scratch = reg_wr && reg_addr == ADDR_SCRATCH && normal_mode;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mask_bits <= MASK_RESET[MASK_KEEP_W-1:0];
    end else if (wr_mask) begin
      mask_bits <= reg_wdata[MASK_KEEP_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      generator_period_select <= 1'b0;
      generator_duty_value    <= '0;
      generator_bank_select   <= '0;
    end else if (restart) begin
      generator_bank_select   <= '0;
    end else if (wr_setup) begin
      generator_period_select <= reg_wdata[BIT_PERIOD];
      generator_duty_value    <= reg_wdata[DUTY_LSB +: DUTY_W];
      generator_bank_select   <= reg_wdata[BANK_LSB +: BANK_W];
    end
  end

  // bank decode; codes 1xx load nothing
  // restart outranks a write in the same cycle, so nothing loads then
  always_comb begin
    gen_load = '0;
    if (wr_setup && !restart && bank_valid(reg_wdata)) begin
      gen_load[reg_wdata[BANK_LSB +: $clog2(NUM_GEN)]] = 1'b1;
    end
  end

  // generators feed only the high-side selectors below
  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_slot
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        gen_cfg[g] <= '0;
      end else if (gen_load[g]) begin
        gen_cfg[g] <= pack_cfg(reg_wdata);
      end
    end

    hs_pwm_gen u_gen (
      .mclk    (mclk),
      .nrst    (nrst),
      .cfg     (gen_cfg[g]),
      .load    (gen_load[g]),
      .pwm_out (generator_out[g]),
      .settled (generator_settled[g])
    );
  end

  always_comb begin
    logic [3:0] code;
    logic [3:0] idx;
    code = '0;
    idx  = '0;
    for (int s = 0; s < NUM_HS; s++) begin
      code = highside_switch_cfg[4*s +: 4];
      idx  = code - HS_CODE_GEN1;
      highside_switch_by_gen[s] = (code[3:2] == HS_CODE_GEN1[3:2]);
      highside_switch_pwm[s]    = highside_switch_by_gen[s] && generator_out[idx[1:0]];
    end
  end

  // scratch only cleared by reset; ignored outside normal mode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      host_config_bits <= '0;
    end else if (wr_scratch) begin
      host_config_bits <= reg_wdata;
    end
  end

  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      ADDR_MASK: begin
        next_rdata[MASK_KEEP_W-1:0] = mask_bits;
      end
      ADDR_SETUP: begin
        next_rdata[BIT_PERIOD]            = generator_period_select;
        next_rdata[DUTY_LSB +: DUTY_W]    = generator_duty_value;
        next_rdata[BANK_LSB +: BANK_W]    = generator_bank_select;
      end
      ADDR_SCRATCH: begin
        next_rdata = normal_mode ? host_config_bits : '0;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // each enabled event pulse, no flag memory so repeats still fire
  // events come as one-cycle pulses, so no edge detector is needed here
  assign irq_hit = (events.bus_ev    && mask_bits[BIT_BUS])
                || (events.temp_ev   && mask_bits[BIT_TEMP])
                || (events.supply_ev && mask_bits[BIT_SUPPLY]);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !irq_hit;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_bus_irq: assert property (events.bus_ev && mask_bits[BIT_BUS] |=> !irq_out_n)
    else $error("bus event gave no interrupt pulse");
  a_temp_irq: assert property (events.temp_ev && mask_bits[BIT_TEMP] |=> !irq_out_n)
    else $error("temperature event gave no interrupt pulse");
  a_supply_irq: assert property (events.supply_ev && mask_bits[BIT_SUPPLY] |=> !irq_out_n)
    else $error("supply event gave no interrupt pulse");
  a_irq_masked_quiet: assert property (!irq_hit |=> irq_out_n)
    else $error("interrupt pulse without enabled event");
  a_mask_restart_keep: assert property (restart && !wr_mask |=> $stable(mask_bits))
    else $error("restart altered lower mask bits");
  a_setup_restart: assert property (
      restart |=> generator_bank_select == '0 && $stable(generator_duty_value))
    else $error("restart handled setup register wrongly");
  a_bank_ignored: assert property (wr_setup && !bank_valid(reg_wdata) |-> gen_load == '0)
    else $error("bank code 1xx loaded a generator");
  a_bank_one_hot: assert property (
      wr_setup && !restart && bank_valid(reg_wdata) |-> $onehot(gen_load))
    else $error("valid bank did not load exactly one generator");
  a_scratch_locked: assert property (!normal_mode |=> $stable(host_config_bits))
    else $error("scratch changed outside normal mode");
  a_reserved_zero: assert property (
      reg_rd && reg_addr == ADDR_SETUP |=> reg_rdata[15] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("reserved setup bits read nonzero");
  a_mask_keep: assert property (!wr_mask |=> $stable(mask_bits))
    else $error("mask changed without a write");
  a_setup_keep: assert property (
      !wr_setup && !restart |=> $stable(generator_duty_value) && $stable(generator_period_select))
    else $error("setup fields changed without a write");
  a_restart_no_load: assert property (restart |-> gen_load == '0)
    else $error("generator loaded during restart");
  a_gen_load_cfg: assert property (
      gen_load[0] |=> gen_cfg[0] == pack_cfg($past(reg_wdata)))
    else $error("generator one did not take the written setting");
  a_gen_load_keep: assert property (!gen_load[0] |=> $stable(gen_cfg[0]))
    else $error("generator one setting changed without a load");
  a_scratch_write: assert property (wr_scratch |=> host_config_bits == $past(reg_wdata))
    else $error("scratch did not take the written word");
  a_scratch_read_closed: assert property (
      reg_rd && reg_addr == ADDR_SCRATCH && !normal_mode |=> reg_rdata == '0)
    else $error("scratch readable outside normal mode");
  a_scratch_read_open: assert property (
      reg_rd && reg_addr == ADDR_SCRATCH && normal_mode |=> reg_rdata == $past(host_config_bits))
    else $error("scratch read returned wrong contents");
endmodule : hs_pwm_irq_mask_regs

// File: hs_pwm_gen_unused_guard.sv
`timescale 1ns/100ps

// File: host_model.sv
// Purpose: host side of the register port, one request at a time
// Assumes: requests launched just after rising mclk
// Notes:   strobes last one cycle; released lines show the inverse of the last value
`timescale 1ns/100ps
module host_model
  import hs_pwm_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // register port
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // access in any mode; scratch reads return zero while normal mode is off
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// File: hs_pwm_irq_mask_regs_tb.sv
// Purpose: self-checking bench for mask, generator setup and scratch registers
// Assumes: 10 MHz mclk, host_model drives the register port
// Notes:   only the fast settle span is timed; duty checked at its constant ends
`timescale 1ns/100ps
module hs_pwm_irq_mask_regs_tb;
  import hs_pwm_pkg::*;
  logic                  mclk;
  logic                  nrst;
  logic                  restart;
  logic                  normal_mode;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata;
  logic [DATA_W-1:0]     reg_rdata;
  event_t                events;
  logic                  irq_out_n;
  logic [4*NUM_HS-1:0]   hs_cfg;
  logic [NUM_HS-1:0]     hs_pwm;
  logic [NUM_HS-1:0]     hs_by_gen;
  logic [NUM_GEN-1:0]    gen_out;
  logic [NUM_GEN-1:0]    gen_settled;
  int                    n_errors;
  int                    n_checks;

  host_model u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  hs_pwm_irq_mask_regs dut (.mclk(mclk), .nrst(nrst), .restart(restart),
    .normal_mode(normal_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .events(events), .irq_out_n(irq_out_n),
    .highside_switch_cfg(hs_cfg), .highside_switch_pwm(hs_pwm),
    .highside_switch_by_gen(hs_by_gen), .generator_out(gen_out),
    .generator_settled(gen_settled));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string what);
    logic [DATA_W-1:0] v;
    u_host.rd(a, v);
    chk(what, v, exp);
  endtask : rchk

  // one event cycle, then the low pulse and its end
  task automatic pulse(input event_t e, input logic fire);
    @(posedge mclk);
    events <= e;
    @(posedge mclk);
    events <= '0;
    #1;
    chk("irq_pulse", {15'h0000, irq_out_n}, {15'h0000, ~fire});
    @(posedge mclk);
    #1;
    chk("irq_idle", {15'h0000, irq_out_n}, 16'h0001);
  endtask : pulse

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    nrst        = 1'b0;
    restart     = 1'b0;
    normal_mode = 1'b1;
    events      = '0;
    hs_cfg      = 12'h000;
    n_errors    = 0;
    n_checks    = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rchk(ADDR_MASK, 16'h0140, "mask_reset");
    rchk(ADDR_SETUP, 16'h0000, "setup_reset");
    rchk(ADDR_SCRATCH, 16'h0000, "scratch_reset");
    for (int i = 0; i < 3; i++) begin
      u_host.wr(ADDR_MASK, 16'h0140 | (16'h0001 << i));
      pulse(event_t'(3'(1 << i)), 1'b1);
      pulse(event_t'(3'(1 << i)), 1'b1);
      u_host.wr(ADDR_MASK, 16'h0140);
      pulse(event_t'(3'(1 << i)), 1'b0);
    end
    u_host.wr(ADDR_SETUP, 16'hFFFF);
    rchk(ADDR_SETUP, 16'h7FF7, "setup_reserved");
    u_host.wr(ADDR_SETUP, 16'h7FF0);
    u_host.wr(ADDR_SETUP, 16'h4001);
    // duty set before switches follow generators
    @(posedge mclk);
    hs_cfg <= {4'h0, 4'h5, 4'h4};
    repeat (10) @(posedge mclk);
    #1;
    chk("gen_out", {12'h000, gen_out}, 16'h0001);
    chk("hs_pwm", {13'h0000, hs_pwm}, 16'h0001);
    chk("hs_by_gen", {13'h0000, hs_by_gen}, 16'h0003);
    u_host.wr(ADDR_SETUP, 16'h7FF5);
    repeat (10) @(posedge mclk);
    #1;
    chk("gen_bank_ignored", {12'h000, gen_out}, 16'h0001);
    u_host.wr(ADDR_SETUP, 16'h4001);
    repeat (STEP_FAST * 1024 - 1) @(posedge mclk);
    #1;
    chk("gen_settled_early", {15'h0000, gen_settled[1]}, 16'h0000);
    @(posedge mclk);
    #1;
    chk("gen_settled", {15'h0000, gen_settled[1]}, 16'h0001);
    u_host.wr(ADDR_MASK, 16'hFFFF);
    rchk(ADDR_MASK, 16'h01FF, "mask_upper");
    u_host.wr(ADDR_SETUP, 16'h7FF3);
    u_host.wr(ADDR_SCRATCH, 16'hA5C3);
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    rchk(ADDR_MASK, 16'h01FF, "mask_restart");
    rchk(ADDR_SETUP, 16'h7FF0, "setup_restart");
    rchk(ADDR_SCRATCH, 16'hA5C3, "scratch_restart");
    @(posedge mclk);
    normal_mode <= 1'b0;
    u_host.wr(ADDR_SCRATCH, 16'h1234);
    rchk(ADDR_SCRATCH, 16'h0000, "scratch_closed");
    @(posedge mclk);
    normal_mode <= 1'b1;
    rchk(ADDR_SCRATCH, 16'hA5C3, "scratch_kept");
    rchk(7'h7F, 16'h0000, "unmapped");
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rchk(ADDR_MASK, 16'h0140, "mask_soft_reset");
    rchk(ADDR_SCRATCH, 16'h0000, "scratch_soft_reset");
    report_and_stop();
  end
endmodule : hs_pwm_irq_mask_regs_tb
